// *** src/enc_fb_pkg.sv ***
// shared constants for the encoder speed feedback monitor
package enc_fb_pkg;
  // clock and time base
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_TIME_MS = 100;
  localparam int GATE_TIME_MS = 10;
  // cycles per millisecond first, so the product stays inside an int
  localparam int TICK_CYCLES = TICK_TIME_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int GATE_CYCLES = GATE_TIME_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int GATES_PER_MIN = (60 * 1000) / GATE_TIME_MS;
  localparam int PCT_SCALE = 100;
  localparam int DIV_HUNDREDS = 100;
  localparam int DIV_M_MAX = 32;
  // register byte offsets
  localparam logic [7:0] OFS_PPR = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_PMON_DIV = 8'h08;
  localparam logic [7:0] OFS_OS_LEVEL = 8'h0C;
  localparam logic [7:0] OFS_OS_DELAY = 8'h10;
  localparam logic [7:0] OFS_DEV_LEVEL = 8'h14;
  localparam logic [7:0] OFS_DEV_DELAY = 8'h18;
  localparam logic [7:0] OFS_MOTOR_TEETH = 8'h1C;
  localparam logic [7:0] OFS_ENC_TEETH = 8'h20;
  localparam logic [7:0] OFS_OC_DELAY = 8'h24;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h28;
  localparam logic [7:0] OFS_MIN_FREQ = 8'h2C;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h30;
  localparam logic [7:0] OFS_AGREE = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_SPEED = 8'h3C;
  // selection register fields
  localparam int SEL_OC_LSB = 0;
  localparam int SEL_OS_LSB = 2;
  localparam int SEL_DEV_LSB = 4;
  localparam int SEL_DIR_BIT = 8;
  localparam int SEL_INTEG_BIT = 9;
  // status register fields
  localparam int ST_OC_BIT = 0;
  localparam int ST_OS_BIT = 1;
  localparam int ST_DEV_BIT = 2;
  localparam int ST_DIR_BIT = 3;
  localparam int ST_ARMED_BIT = 4;
  // reset values
  localparam logic [15:0] RST_PPR = 16'h0400;
  localparam logic [1:0] RST_OC_ACT = 2'h1;
  localparam logic [1:0] RST_OS_ACT = 2'h1;
  localparam logic [1:0] RST_DEV_ACT = 2'h3;
  localparam logic [7:0] RST_PMON_DIV = 8'h01;
  localparam logic [7:0] RST_OS_LEVEL = 8'h73;
  localparam logic [7:0] RST_OS_DELAY = 8'h0A;
  localparam logic [7:0] RST_DEV_LEVEL = 8'h0A;
  localparam logic [7:0] RST_DEV_DELAY = 8'h05;
  localparam logic [7:0] RST_OC_DELAY = 8'h14;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1770;
  localparam logic [15:0] RST_MIN_FREQ = 16'h0032;
  localparam logic [15:0] RST_MAX_SPEED = 16'h0708;
  localparam logic [15:0] RST_AGREE = 16'h0014;
  // stop methods
  typedef enum logic [1:0] {
    STOP_RAMP = 2'h0,
    STOP_COAST = 2'h1,
    STOP_FAST = 2'h2,
    STOP_NONE = 2'h3
  } stop_method_t;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** src/fault_qual_timer.sv ***
// time-qualified fault latch: counts base ticks while a condition holds
`timescale 1ns/10ps
module fault_qual_timer #(
  parameter bit STRICT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // qualification
  input wire logic tick,
  input wire logic cond,
  input wire logic [7:0] delay,
  // latch control
  input wire logic clear,
  output logic fault
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic fault_q;
  logic expired;

  // strict means the condition must outlast the delay, not just reach it
  assign expired = STRICT ? (cnt_q > delay) : (cnt_q >= delay);
  assign cnt_d = !cond ? 8'h00 :
    (tick && cnt_q != 8'hFF) ? cnt_q + 8'h01 : cnt_q;
  assign fault = fault_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 8'h00;
      fault_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      // a new fault in the clearing cycle survives the clear
      fault_q <= (cond && expired) || (fault_q && !clear);
    end
  end
endmodule

// *** src/encoder_speed_feedback_monitor.sv ***
// encoder speed feedback, pulse monitor divider and fault detection
`timescale 1ns/10ps
module encoder_speed_feedback_monitor #(
  parameter int TICK_CYCLES = enc_fb_pkg::TICK_CYCLES,
  parameter int GATE_CYCLES = enc_fb_pkg::GATE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // shaft encoder
  input wire logic enc_a,
  input wire logic enc_b,
  // drive state
  input wire logic run,
  input wire logic accel_decel,
  input wire logic card_present,
  input wire logic [15:0] freq_ref,
  input wire logic [15:0] speed_ref,
  input wire logic [15:0] estimated_speed,
  // outputs to the drive
  output logic pulse_monitor,
  output logic integral_enable,
  output logic stop_request,
  output logic [1:0] stop_method,
  output logic [15:0] speed_monitor
);
  // settings
  logic [15:0] pulses_per_rev_q;
  logic [1:0] open_circuit_action_sel_q;
  logic [1:0] overspeed_action_sel_q;
  logic [1:0] deviation_action_sel_q;
  logic encoder_direction_sel_q;
  logic accel_integral_enable_q;
  logic [7:0] pulse_monitor_divider_q;
  logic [7:0] overspeed_level_q;
  logic [7:0] overspeed_delay_q;
  logic [7:0] deviation_level_q;
  logic [7:0] deviation_delay_q;
  logic [7:0] motor_side_teeth_q;
  logic [7:0] encoder_side_teeth_q;
  logic [7:0] open_circuit_delay_q;
  logic [15:0] max_freq_q;
  logic [15:0] minimum_output_frequency_q;
  logic [15:0] max_speed_q;
  logic [15:0] speed_agree_width_q;

  // ---------------- encoder front end ----------------
  logic [1:0] a_sync_q;
  logic [1:0] b_sync_q;
  logic a_prev_q;
  logic a_rise;
  logic a_leads;
  logic forward;
  logic dir_q;
  assign a_rise = a_sync_q[1] && !a_prev_q;
  // on a rising a edge, b still low means a leads
  assign a_leads = !b_sync_q[1];
  assign forward = a_leads ^ encoder_direction_sel_q;

  // ---------------- gate window and speed ----------------
  logic [31:0] gate_cnt_q;
  logic [15:0] pulse_cnt_q;
  logic [15:0] pulses_q;
  logic gate_end;
  logic [47:0] speed_num;
  logic [47:0] speed_den;
  logic [47:0] speed_full;
  logic [15:0] enc_speed_q;
  logic [7:0] et;
  logic [7:0] mt;
  assign gate_end = gate_cnt_q == 32'(GATE_CYCLES - 1);
  // a zero tooth count is taken as one tooth
  assign et = encoder_side_teeth_q == 8'h00 ? 8'h01 : encoder_side_teeth_q;
  assign mt = motor_side_teeth_q == 8'h00 ? 8'h01 : motor_side_teeth_q;
  assign speed_num = 48'(pulses_q) * 48'(enc_fb_pkg::GATES_PER_MIN) *
    48'(et);
  assign speed_den = (pulses_per_rev_q == 16'h0000 ? 48'h0000_0000_0001 :
    48'(pulses_per_rev_q)) * 48'(mt);
  assign speed_full = speed_num / speed_den;
  // one cycle late so the divider has a register on each side

  // ---------------- pulse monitor divider ----------------
  logic pm_n;
  logic [7:0] pm_m_raw;
  logic [7:0] pm_m;
  logic [7:0] pm_step;
  logic [8:0] pm_sum;
  logic [7:0] pm_acc_q;
  logic pm_out_q;
  assign pm_n = pulse_monitor_divider_q >= 8'(enc_fb_pkg::DIV_HUNDREDS);
  assign pm_m_raw = pm_n ?
    pulse_monitor_divider_q - 8'(enc_fb_pkg::DIV_HUNDREDS) :
    pulse_monitor_divider_q;
  assign pm_step = pm_n ? 8'h02 : 8'h01;
  // clamp so the ratio never leaves 1/32..1
  assign pm_m = pm_m_raw > 8'(enc_fb_pkg::DIV_M_MAX) ?
    8'(enc_fb_pkg::DIV_M_MAX) :
    (pm_m_raw < pm_step ? pm_step : pm_m_raw);
  assign pm_sum = {1'b0, pm_acc_q} + {1'b0, pm_step};

  // ---------------- fault conditions ----------------
  logic tick;
  logic [31:0] tick_cnt_q;
  logic [47:0] speed_pct;
  logic [47:0] os_limit;
  logic [47:0] dev_limit;
  logic [15:0] dev_abs;
  logic [47:0] dev_pct;
  logic ref_above_floor;
  logic no_pulse_q;
  logic oc_cond;
  logic os_cond;
  logic dev_cond;
  logic armed_q;
  logic oc_fault;
  logic os_fault;
  logic dev_fault;
  logic fault_clear;
  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);
  assign ref_above_floor = run &&
    ((48'(freq_ref) * 48'(enc_fb_pkg::PCT_SCALE) > 48'(max_freq_q)) ||
    (freq_ref > minimum_output_frequency_q));
  // restart the absence timer on every rising edge of encoder line a
  assign oc_cond = ref_above_floor && !a_rise && no_pulse_q;
  assign speed_pct = 48'(enc_speed_q) * 48'(enc_fb_pkg::PCT_SCALE);
  assign os_limit = 48'(overspeed_level_q) * 48'(max_speed_q);
  assign os_cond = speed_pct > os_limit;
  assign dev_abs = speed_ref > enc_speed_q ? speed_ref - enc_speed_q :
    enc_speed_q - speed_ref;
  assign dev_pct = 48'(dev_abs) * 48'(enc_fb_pkg::PCT_SCALE);
  assign dev_limit = 48'(deviation_level_q) * 48'(max_speed_q);
  assign dev_cond = armed_q && dev_pct > dev_limit;

  fault_qual_timer #(.STRICT(1'b0)) u_oc_timer (
    .aclk(aclk), .aresetn(aresetn), .tick(tick), .cond(oc_cond),
    .delay(open_circuit_delay_q), .clear(fault_clear), .fault(oc_fault)
  );
  fault_qual_timer #(.STRICT(1'b1)) u_os_timer (
    .aclk(aclk), .aresetn(aresetn), .tick(tick), .cond(os_cond),
    .delay(overspeed_delay_q), .clear(fault_clear), .fault(os_fault)
  );
  fault_qual_timer #(.STRICT(1'b1)) u_dev_timer (
    .aclk(aclk), .aresetn(aresetn), .tick(tick), .cond(dev_cond),
    .delay(deviation_delay_q), .clear(fault_clear), .fault(dev_fault)
  );

  // stop method of the highest-priority latched fault
  logic [1:0] act_sel;
  logic act_any;
  assign act_sel = oc_fault ? open_circuit_action_sel_q :
    os_fault ? overspeed_action_sel_q :
    dev_fault ? deviation_action_sel_q :
    enc_fb_pkg::STOP_NONE;
  assign act_any = (oc_fault &&
    open_circuit_action_sel_q != enc_fb_pkg::STOP_NONE) ||
    (os_fault && overspeed_action_sel_q != enc_fb_pkg::STOP_NONE) ||
    (dev_fault && deviation_action_sel_q != enc_fb_pkg::STOP_NONE);

  // ---------------- axi4-lite slave ----------------
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic do_write;
  logic wr_hit;
  logic [15:0] wv;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wv = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
    w_strb_q[0] ? w_data_q[7:0] : 8'h00};
  assign wr_hit = aw_addr_q <= enc_fb_pkg::OFS_STATUS &&
    aw_addr_q[1:0] == 2'h0;
  assign fault_clear = do_write && aw_addr_q == enc_fb_pkg::OFS_STATUS &&
    w_strb_q[0];
  assign rd_addr = s_axi_araddr;
  assign rd_hit = rd_addr <= enc_fb_pkg::OFS_SPEED && rd_addr[1:0] == 2'h0;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      enc_fb_pkg::OFS_PPR: rd_data = 32'(pulses_per_rev_q);
      enc_fb_pkg::OFS_SEL: rd_data = 32'({accel_integral_enable_q,
        encoder_direction_sel_q, 2'h0, deviation_action_sel_q,
        overspeed_action_sel_q, open_circuit_action_sel_q});
      enc_fb_pkg::OFS_PMON_DIV: rd_data = 32'(pulse_monitor_divider_q);
      enc_fb_pkg::OFS_OS_LEVEL: rd_data = 32'(overspeed_level_q);
      enc_fb_pkg::OFS_OS_DELAY: rd_data = 32'(overspeed_delay_q);
      enc_fb_pkg::OFS_DEV_LEVEL: rd_data = 32'(deviation_level_q);
      enc_fb_pkg::OFS_DEV_DELAY: rd_data = 32'(deviation_delay_q);
      enc_fb_pkg::OFS_MOTOR_TEETH: rd_data = 32'(motor_side_teeth_q);
      enc_fb_pkg::OFS_ENC_TEETH: rd_data = 32'(encoder_side_teeth_q);
      enc_fb_pkg::OFS_OC_DELAY: rd_data = 32'(open_circuit_delay_q);
      enc_fb_pkg::OFS_MAX_FREQ: rd_data = 32'(max_freq_q);
      enc_fb_pkg::OFS_MIN_FREQ: rd_data = 32'(minimum_output_frequency_q);
      enc_fb_pkg::OFS_MAX_SPEED: rd_data = 32'(max_speed_q);
      enc_fb_pkg::OFS_AGREE: rd_data = 32'(speed_agree_width_q);
      enc_fb_pkg::OFS_STATUS: rd_data = 32'({armed_q, dir_q, dev_fault,
        os_fault, oc_fault});
      enc_fb_pkg::OFS_SPEED: rd_data = 32'(speed_monitor);
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= enc_fb_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= enc_fb_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? enc_fb_pkg::RESP_OKAY :
          enc_fb_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? enc_fb_pkg::RESP_OKAY :
          enc_fb_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // settings registers; writes to the status word only clear faults
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulses_per_rev_q <= enc_fb_pkg::RST_PPR;
      open_circuit_action_sel_q <= enc_fb_pkg::RST_OC_ACT;
      overspeed_action_sel_q <= enc_fb_pkg::RST_OS_ACT;
      deviation_action_sel_q <= enc_fb_pkg::RST_DEV_ACT;
      encoder_direction_sel_q <= 1'b0;
      accel_integral_enable_q <= 1'b0;
      pulse_monitor_divider_q <= enc_fb_pkg::RST_PMON_DIV;
      overspeed_level_q <= enc_fb_pkg::RST_OS_LEVEL;
      overspeed_delay_q <= enc_fb_pkg::RST_OS_DELAY;
      deviation_level_q <= enc_fb_pkg::RST_DEV_LEVEL;
      deviation_delay_q <= enc_fb_pkg::RST_DEV_DELAY;
      motor_side_teeth_q <= 8'h00;
      encoder_side_teeth_q <= 8'h00;
      open_circuit_delay_q <= enc_fb_pkg::RST_OC_DELAY;
      max_freq_q <= enc_fb_pkg::RST_MAX_FREQ;
      minimum_output_frequency_q <= enc_fb_pkg::RST_MIN_FREQ;
      max_speed_q <= enc_fb_pkg::RST_MAX_SPEED;
      speed_agree_width_q <= enc_fb_pkg::RST_AGREE;
    end
    else if (do_write)
    begin
      case (aw_addr_q)
        enc_fb_pkg::OFS_PPR: pulses_per_rev_q <= wv;
        enc_fb_pkg::OFS_SEL:
        begin
          open_circuit_action_sel_q <= wv[enc_fb_pkg::SEL_OC_LSB +: 2];
          overspeed_action_sel_q <= wv[enc_fb_pkg::SEL_OS_LSB +: 2];
          deviation_action_sel_q <= wv[enc_fb_pkg::SEL_DEV_LSB +: 2];
          encoder_direction_sel_q <= wv[enc_fb_pkg::SEL_DIR_BIT];
          accel_integral_enable_q <= wv[enc_fb_pkg::SEL_INTEG_BIT];
        end
        enc_fb_pkg::OFS_PMON_DIV: pulse_monitor_divider_q <= wv[7:0];
        enc_fb_pkg::OFS_OS_LEVEL: overspeed_level_q <= wv[7:0];
        enc_fb_pkg::OFS_OS_DELAY: overspeed_delay_q <= wv[7:0];
        enc_fb_pkg::OFS_DEV_LEVEL: deviation_level_q <= wv[7:0];
        enc_fb_pkg::OFS_DEV_DELAY: deviation_delay_q <= wv[7:0];
        enc_fb_pkg::OFS_MOTOR_TEETH: motor_side_teeth_q <= wv[7:0];
        enc_fb_pkg::OFS_ENC_TEETH: encoder_side_teeth_q <= wv[7:0];
        enc_fb_pkg::OFS_OC_DELAY: open_circuit_delay_q <= wv[7:0];
        enc_fb_pkg::OFS_MAX_FREQ: max_freq_q <= wv;
        enc_fb_pkg::OFS_MIN_FREQ: minimum_output_frequency_q <= wv;
        enc_fb_pkg::OFS_MAX_SPEED: max_speed_q <= wv;
        enc_fb_pkg::OFS_AGREE: speed_agree_width_q <= wv;
        default: ;
      endcase
    end
  end

  // datapath
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_prev_q <= 1'b0;
      dir_q <= 1'b0;
      gate_cnt_q <= 32'h0000_0000;
      pulse_cnt_q <= 16'h0000;
      pulses_q <= 16'h0000;
      enc_speed_q <= 16'h0000;
      pm_acc_q <= 8'h00;
      pm_out_q <= 1'b0;
      tick_cnt_q <= 32'h0000_0000;
      no_pulse_q <= 1'b0;
      armed_q <= 1'b0;
      pulse_monitor <= 1'b0;
      integral_enable <= 1'b1;
      stop_request <= 1'b0;
      stop_method <= enc_fb_pkg::STOP_NONE;
      speed_monitor <= 16'h0000;
    end
    else
    begin
      a_sync_q <= {a_sync_q[0], enc_a};
      b_sync_q <= {b_sync_q[0], enc_b};
      a_prev_q <= a_sync_q[1];
      if (a_rise)
        dir_q <= forward;
      gate_cnt_q <= gate_end ? 32'h0000_0000 : gate_cnt_q + 32'h0000_0001;
      if (gate_end)
      begin
        pulses_q <= pulse_cnt_q;
        pulse_cnt_q <= 16'(a_rise);
        // a window with no edge at all marks the feedback as missing
        no_pulse_q <= pulse_cnt_q == 16'h0000 && !a_rise;
      end
      else if (a_rise && pulse_cnt_q != 16'hFFFF)
        pulse_cnt_q <= pulse_cnt_q + 16'h0001;
      if (a_rise)
        no_pulse_q <= 1'b0;
      enc_speed_q <= speed_full[47:16] != 32'h0000_0000 ? 16'hFFFF :
        speed_full[15:0];
      if (a_rise)
      begin
        pm_acc_q <= pm_sum >= {1'b0, pm_m} ? 8'(pm_sum - {1'b0, pm_m}) :
          pm_sum[7:0];
        pm_out_q <= pm_sum >= {1'b0, pm_m};
      end
      else
        pm_out_q <= 1'b0;
      pulse_monitor <= pm_out_q;
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (!run)
        armed_q <= 1'b0;
      else if (dev_abs <= speed_agree_width_q)
        armed_q <= 1'b1;
      integral_enable <= accel_decel ? accel_integral_enable_q : 1'b1;
      stop_request <= act_any;
      stop_method <= act_sel;
      speed_monitor <= card_present ? enc_speed_q : estimated_speed;
    end
  end
endmodule

// *** testbench/enc_fb_properties.sv ***
// concurrent checks on the encoder speed feedback monitor ports
`timescale 1ns/10ps
module enc_fb_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  input wire logic accel_decel,
  input wire logic card_present,
  input wire logic [15:0] estimated_speed,
  input wire logic pulse_monitor,
  input wire logic integral_enable,
  input wire logic stop_request,
  input wire logic [15:0] speed_monitor
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_est_monitor: assert property (
    !card_present |=> speed_monitor == $past(estimated_speed))
    else $error("monitor misses estimate");
  chk_integral_on: assert property (
    !accel_decel |=> integral_enable)
    else $error("integral off outside ramps");
  // a clearing write lands a few cycles after its data beat
  chk_fault_latch: assert property (
    stop_request && !s_axi_wvalid && !$past(s_axi_wvalid)
    && !s_axi_bvalid && !$past(s_axi_bvalid) |=> stop_request)
    else $error("stop released without clear");
  chk_monitor_pulse: assert property (
    pulse_monitor |=> !pulse_monitor)
    else $error("monitor pulse too long");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  chk_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind encoder_speed_feedback_monitor enc_fb_checker u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .accel_decel, .card_present, .estimated_speed, .pulse_monitor,
  .integral_enable, .stop_request, .speed_monitor);

// *** testbench/shaft_encoder_model.sv ***
// behavioural quadrature shaft encoder
`timescale 1ns/10ps
module shaft_encoder_model (
  // clock
  input wire logic aclk,
  // motion from the bench
  input wire logic en,
  input wire logic ccw,
  input wire logic [3:0] q,
  // encoder lines
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_q = 2'h0;
  logic [3:0] cnt_q = 4'h0;
  // counter-clockwise steps the phase up, so a leads b
  assign enc_a = ph_q == 2'h1 || ph_q == 2'h2;
  assign enc_b = ph_q[1];
  // a stopped shaft holds both lines, as a real one does
  always @(posedge aclk)
  begin
    if (en && cnt_q >= q)
    begin
      cnt_q <= 4'h0;
      ph_q <= ccw ? ph_q + 2'h1 : ph_q - 2'h1;
    end
    else if (en)
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the encoder speed feedback monitor
`timescale 1ns/10ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic run = 1'b0, accel_decel = 1'b0, card_present = 1'b1;
  logic [15:0] freq_ref = 16'h0000, speed_ref = 16'h0000;
  logic [15:0] estimated_speed = 16'h0000;
  logic en = 1'b1, ccw = 1'b1;
  logic [3:0] q = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, enc_a, enc_b, pulse_monitor, integral_enable;
  logic stop_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, stop_method, rd_r, b_r;
  logic [31:0] s_axi_rdata, rd_d;
  logic [15:0] speed_monitor;
  int n_errors = 0, n_tests = 0, cyc = 0, pm = 0;
  initial forever #2 aclk = ~aclk;
  // short base tick and gate keep fault delays to a few hundred cycles
  encoder_speed_feedback_monitor #(.TICK_CYCLES(20), .GATE_CYCLES(20)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .enc_a, .enc_b, .run, .accel_decel, .card_present, .freq_ref, .speed_ref,
    .estimated_speed, .pulse_monitor, .integral_enable, .stop_request,
    .stop_method, .speed_monitor);
  shaft_encoder_model enc (.aclk, .en, .ccw, .q, .enc_a, .enc_b);
  task end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (pulse_monitor === 1'b1)
      pm++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // ready is raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid | s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    b_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_d, e);
  endtask
  task automatic wfault(input int lim);
    for (int i = 0; i < lim && stop_request !== 1'b1; i++) @(posedge aclk);
  endtask
  task automatic clr;
    wr(enc_fb_pkg::OFS_STATUS, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    chk(stop_request, 1'b0);
  endtask
  task automatic dirc(input logic [31:0] s, input logic c, input logic e);
    ccw <= c;
    wr(enc_fb_pkg::OFS_SEL, s);
    repeat (30) @(posedge aclk);
    rd(enc_fb_pkg::OFS_STATUS);
    chk(rd_d[enc_fb_pkg::ST_DIR_BIT], e);
  endtask
  // 128 cycles hold exactly 32 encoder periods; phase allows one off
  task automatic pmc(input logic [31:0] div, input int e);
    int p0;
    wr(enc_fb_pkg::OFS_PMON_DIV, div);
    repeat (8) @(posedge aclk);
    p0 = pm;
    repeat (128) @(posedge aclk);
    chk(32'((pm - p0 - e) * (pm - p0 - e) <= 1), 32'h0000_0001);
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(stop_method, enc_fb_pkg::STOP_NONE);
    rc(enc_fb_pkg::OFS_PPR, 32'h0000_0400);
    rc(enc_fb_pkg::OFS_SEL, 32'h0000_0035);
    rc(enc_fb_pkg::OFS_OS_LEVEL, 32'h0000_0073);
    rc(enc_fb_pkg::OFS_OS_DELAY, 32'h0000_000A);
    rc(enc_fb_pkg::OFS_DEV_LEVEL, 32'h0000_000A);
    rc(enc_fb_pkg::OFS_OC_DELAY, 32'h0000_0014);
    rd(8'h40);
    chk(rd_r, enc_fb_pkg::RESP_SLVERR);
    wr(enc_fb_pkg::OFS_SPEED, 32'h0000_FFFF);
    chk(b_r, enc_fb_pkg::RESP_SLVERR);
    // the gate spans whole encoder periods, so five pulses each
    wr(enc_fb_pkg::OFS_PPR, 32'h0000_0064);
    repeat (60) @(posedge aclk);
    chk(speed_monitor, 5 * enc_fb_pkg::GATES_PER_MIN / 100);
    wr(enc_fb_pkg::OFS_ENC_TEETH, 32'h0000_0003);
    wr(enc_fb_pkg::OFS_MOTOR_TEETH, 32'h0000_0002);
    repeat (60) @(posedge aclk);
    rc(enc_fb_pkg::OFS_SPEED, 5 * enc_fb_pkg::GATES_PER_MIN * 3 / 200);
    estimated_speed <= 16'h1234;
    card_present <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(speed_monitor, 32'h0000_1234);
    card_present <= 1'b1;
    dirc(32'h0000_0135, 1'b0, 1'b1);
    dirc(32'h0000_0035, 1'b0, 1'b0);
    dirc(32'h0000_0035, 1'b1, 1'b1);
    pmc(32'h0000_0001, 32);
    pmc(32'h0000_0002, 16);
    pmc(32'h0000_0084, 2);
    pmc(32'h0000_0064, 32);
    accel_decel <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(integral_enable, 1'b0);
    wr(enc_fb_pkg::OFS_SEL, 32'h0000_0235);
    repeat (3) @(posedge aclk);
    chk(integral_enable, 1'b1);
    accel_decel <= 1'b0;
    en <= 1'b0;
    wr(enc_fb_pkg::OFS_OC_DELAY, 32'h0000_0002);
    run <= 1'b1;
    freq_ref <= 16'h0032;
    repeat (300) @(posedge aclk);
    chk(stop_request, 1'b0);
    freq_ref <= 16'h03E8;
    repeat (15) @(posedge aclk);
    chk(stop_request, 1'b0);
    wfault(200);
    chk(stop_request, 1'b1);
    chk(stop_method, enc_fb_pkg::STOP_COAST);
    run <= 1'b0;
    repeat (50) @(posedge aclk);
    chk(stop_request, 1'b1);
    clr;
    en <= 1'b1;
    wr(enc_fb_pkg::OFS_SEL, 32'h0000_0039);
    wr(enc_fb_pkg::OFS_OS_DELAY, 32'h0000_0008);
    wr(enc_fb_pkg::OFS_PPR, 32'h0000_000A);
    repeat (100) @(posedge aclk);
    chk(stop_request, 1'b0);
    wfault(400);
    chk(stop_method, enc_fb_pkg::STOP_FAST);
    wr(enc_fb_pkg::OFS_PPR, 32'h0000_0064);
    repeat (60) @(posedge aclk);
    clr;
    wr(enc_fb_pkg::OFS_SEL, 32'h0000_0005);
    speed_ref <= 16'h03E8;
    repeat (300) @(posedge aclk);
    chk(stop_request, 1'b0);
    speed_ref <= 16'h01C2;
    run <= 1'b1;
    repeat (30) @(posedge aclk);
    rd(enc_fb_pkg::OFS_STATUS);
    chk(rd_d[enc_fb_pkg::ST_ARMED_BIT], 1'b1);
    speed_ref <= 16'h03E8;
    repeat (60) @(posedge aclk);
    chk(stop_request, 1'b0);
    wfault(400);
    chk(stop_method, enc_fb_pkg::STOP_RAMP);
    wr(enc_fb_pkg::OFS_SEL, 32'h0000_0035);
    chk(stop_request, 1'b0);
    end_sim();
  end
endmodule
